//--- hw/power_mode_two_config_regs.sv
// What this block does
// - core buck code 0..40 steps 25 mV from 0.5 V; above saturates; 63 gives 1.8 V
// - button bit 0: valid falling edge requests return to mode zero, only while in mode two
// - button bit 1, reset value: falling edge causes no mode switch
// - system buck target is base voltage plus 1.2 V when offset bit set
// - system buck base 1.5 V..2.1 V in 25 mV, saturating above 24, reset 12
// - four rail enables, 1 on, 0 off, all reset to 1
// - always-on code 1.7 V..1.9 V in 25 mV, saturating above 8, reset 4
module power_mode_two_config_regs
(
  // clock and reset
  input  wire logic                       clk_sys,
  input  wire logic                       reset,
  // register port
  input  wire logic [7:0]                 reg_addr,
  input  wire logic                       reg_wr,
  input  wire logic [7:0]                 reg_wdata,
  input  wire logic                       reg_rd,
  output logic      [7:0]                 reg_rdata,
  // mode and button
  input  wire logic [1:0]                 active_mode,
  input  wire logic                       button_fall_valid,
  output logic                            mode_zero_req,
  // regulator controls
  output logic                            rail_apply,
  output mode_two_cfg_pkg::rail_ctrl_t    rail_ctrl
);
  import mode_two_cfg_pkg::*;

  function automatic logic [11:0] steps_mv(input logic [5:0] code);
    steps_mv = 12'(code) * STEP_MV;
  endfunction

  logic [5:0] core_buck_level_code_q;
  logic [7:0] button_sys_q;
  logic [7:0] aon_enables_q;
  logic [7:0] reg_rdata_d;
  logic       mode_zero_req_d;
  rail_ctrl_t rail_ctrl_d;
  logic       rail_apply_d;

  wire        sel_core    = (reg_addr == CORE_LEVEL_OFS);
  wire        sel_button  = (reg_addr == BUTTON_SYS_OFS);
  wire        sel_aon     = (reg_addr == AON_ENABLES_OFS);
  wire        mode_two_on = (active_mode == MODE_TWO);

  wire        button_cfg          = button_sys_q[BUTTON_CFG_BIT];
  wire        sys_buck_offset_sel = button_sys_q[SYS_OFFSET_BIT];
  wire [4:0]  sys_buck_base_code  = button_sys_q[SYS_BASE_MSB:0];
  wire [3:0]  aon_reg_level_code  = aon_enables_q[AON_CODE_MSB:AON_CODE_LSB];

  // core buck decode
  wire [5:0]  core_sat  = (core_buck_level_code_q > CORE_TOP_CODE)
                          ? CORE_TOP_CODE : core_buck_level_code_q;
  wire [11:0] core_mv   = (core_buck_level_code_q == CORE_FIX_CODE)
                          ? CORE_FIX_MV
                          : CORE_BASE_MV + steps_mv(core_sat);

  // system buck decode
  wire [4:0]  sys_sat   = (sys_buck_base_code > SYS_TOP_CODE)
                          ? SYS_TOP_CODE : sys_buck_base_code;
  wire [11:0] sys_off   = sys_buck_offset_sel ? SYS_OFFSET_MV : 12'h000;
  wire [11:0] sys_mv    = SYS_BASE_MV + steps_mv({1'b0, sys_sat})
                          + sys_off;

  // always-on regulator decode
  wire [3:0]  aon_sat   = (aon_reg_level_code > AON_TOP_CODE)
                          ? AON_TOP_CODE : aon_reg_level_code;
  wire [11:0] aon_mv    = AON_BASE_MV + steps_mv({2'b00, aon_sat});

  // readback; unmapped offsets read zero
  assign reg_rdata_d = sel_core   ? {2'b00, core_buck_level_code_q} :
                       sel_button ? button_sys_q :
                       sel_aon    ? aon_enables_q : 8'h00;

  // button only matters while mode two settings are live
  assign mode_zero_req_d = button_fall_valid && mode_two_on
                           && !button_cfg
                           && (active_mode != MODE_ZERO);

  // outside mode two the stored values are held but not driven out
  assign rail_apply_d = mode_two_on;
  assign rail_ctrl_d  = mode_two_on
                        ? '{core_buck_mv:          core_mv,
                            sys_buck_mv:           sys_mv,
                            aon_reg_mv:            aon_mv,
                            core_buck_enable:      aon_enables_q[CORE_EN_BIT],
                            sys_buck_enable:       aon_enables_q[SYS_EN_BIT],
                            aon_reg_enable:        aon_enables_q[AON_EN_BIT],
                            sys_linear_reg_enable: aon_enables_q[LIN_EN_BIT]}
                        : '0;

  // per register write enables
  wire        wr_core     = reg_wr && sel_core;
  wire        wr_button   = reg_wr && sel_button;
  wire        wr_aon      = reg_wr && sel_aon;

  // upper two bits of the core register are not stored
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
      core_buck_level_code_q <= CORE_CODE_RST;
    else if (wr_core)
      core_buck_level_code_q <= reg_wdata[5:0];
  end

  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
      button_sys_q <= BUTTON_SYS_RST;
    else if (wr_button)
      button_sys_q <= reg_wdata;
  end

  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
      aon_enables_q <= AON_ENABLES_RST;
    else if (wr_aon)
      aon_enables_q <= reg_wdata;
  end

  // read data holds until the next read strobe
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
      reg_rdata <= 8'h00;
    else if (reg_rd)
      reg_rdata <= reg_rdata_d;
  end

  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
      mode_zero_req <= 1'h0;
    else
      mode_zero_req <= mode_zero_req_d;
  end

  // one cycle behind the mode input, glitch free toward the regulators
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
      rail_apply <= 1'h0;
    else
      rail_apply <= rail_apply_d;
  end

  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
      rail_ctrl <= '0;
    else
      rail_ctrl <= rail_ctrl_d;
  end

endmodule

//--- hw/mode_two_cfg_pkg.sv
package mode_two_cfg_pkg;

  // register offsets
  localparam logic [7:0] CORE_LEVEL_OFS   = 8'h2A;
  localparam logic [7:0] BUTTON_SYS_OFS   = 8'h2B;
  localparam logic [7:0] AON_ENABLES_OFS  = 8'h2C;

  // reset values
  localparam logic [5:0] CORE_CODE_RST    = 6'h1C;
  localparam logic [7:0] BUTTON_SYS_RST   = 8'h4C;
  localparam logic [7:0] AON_ENABLES_RST  = 8'h4F;

  // field positions, button and system buck register
  localparam int RSVD_BIT        = 7;
  localparam int BUTTON_CFG_BIT  = 6;
  localparam int SYS_OFFSET_BIT  = 5;
  localparam int SYS_BASE_MSB    = 4;
  // field positions, always-on level and enables register
  localparam int AON_CODE_MSB    = 7;
  localparam int AON_CODE_LSB    = 4;
  localparam int CORE_EN_BIT     = 3;
  localparam int SYS_EN_BIT      = 2;
  localparam int AON_EN_BIT      = 1;
  localparam int LIN_EN_BIT      = 0;

  // mode settings
  localparam logic [1:0] MODE_ZERO = 2'h0;
  localparam logic [1:0] MODE_TWO  = 2'h2;

  // voltage decode, millivolts
  localparam logic [11:0] STEP_MV        = 12'h019;
  localparam logic [11:0] CORE_BASE_MV   = 12'h1F4;
  localparam logic [5:0]  CORE_TOP_CODE  = 6'h28;
  localparam logic [5:0]  CORE_FIX_CODE  = 6'h3F;
  localparam logic [11:0] CORE_FIX_MV    = 12'h708;
  localparam logic [11:0] SYS_BASE_MV    = 12'h5DC;
  localparam logic [4:0]  SYS_TOP_CODE   = 5'h18;
  localparam logic [11:0] SYS_OFFSET_MV  = 12'h4B0;
  localparam logic [11:0] AON_BASE_MV    = 12'h6A4;
  localparam logic [3:0]  AON_TOP_CODE   = 4'h8;

  typedef struct packed {
    logic [11:0] core_buck_mv;
    logic [11:0] sys_buck_mv;
    logic [11:0] aon_reg_mv;
    logic        core_buck_enable;
    logic        sys_buck_enable;
    logic        aon_reg_enable;
    logic        sys_linear_reg_enable;
  } rail_ctrl_t;

endpackage

//--- verif/cfg_rail_monitor.sv
module cfg_rail_monitor
  import mode_two_cfg_pkg::*;
(
  // clock and reset
  input wire logic       clk_sys,
  input wire logic       reset,
  // register read side
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  // mode, button, rails
  input wire logic [1:0] active_mode,
  input wire logic       button_fall_valid,
  input wire logic       mode_zero_req,
  input wire logic       rail_apply,
  input wire rail_ctrl_t rail_ctrl
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  a_apply_tracks_mode: assert property (
    rail_apply == ($past(active_mode) == MODE_TWO)) else $error("apply");
  a_rails_off_zero: assert property (
    !rail_apply |-> rail_ctrl == '0) else $error("rails not off");
  a_core_range: assert property (
    rail_apply |-> rail_ctrl.core_buck_mv inside {[500:1500], 1800})
    else $error("core level");
  a_sys_range: assert property (
    rail_apply |-> rail_ctrl.sys_buck_mv inside {[1500:2100], [2700:3300]})
    else $error("sys level");
  a_aon_range: assert property (
    rail_apply |-> rail_ctrl.aon_reg_mv inside {[1700:1900]})
    else $error("aon level");
  a_req_has_cause: assert property (
    mode_zero_req |-> $past(button_fall_valid) &&
    $past(active_mode) == MODE_TWO) else $error("stray request");
  a_req_one_pulse: assert property (
    mode_zero_req |=> !mode_zero_req || $past(button_fall_valid))
    else $error("request too long");
  a_rdata_holds: assert property (
    !reg_rd |=> $stable(reg_rdata)) else $error("read data moved");
  c_request: cover property (mode_zero_req);
  c_apply: cover property ($rose(rail_apply));
  c_core_fixed: cover property (rail_apply && rail_ctrl.core_buck_mv == 1800);
endmodule

bind power_mode_two_config_regs cfg_rail_monitor mon (.clk_sys, .reset,
  .reg_rd, .reg_rdata, .active_mode, .button_fall_valid, .mode_zero_req,
  .rail_apply, .rail_ctrl);

//--- verif/host_model.sv
module host_model (
  input  wire logic       clk_sys,
  output logic      [7:0] reg_addr,
  output logic            reg_wr,
  output logic      [7:0] reg_wdata,
  output logic            reg_rd,
  input  wire logic [7:0] reg_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  initial {reg_addr, reg_wr, reg_wdata, reg_rd} = '0;
  // one strobe cycle; idle lines inverted so stale data never passes
  task automatic xfer(input logic w, input logic [7:0] a, d,
                      output logic [7:0] q);
    @(negedge clk_sys);
    {reg_wr, reg_rd, reg_addr, reg_wdata} = {w, !w, a, d};
    @(negedge clk_sys);
    {reg_wr, reg_rd, reg_addr, reg_wdata} = {2'b00, ~a, ~d};
    q = reg_rdata;
  endtask
endmodule

//--- verif/tb.sv
module tb;
  import mode_two_cfg_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = 0, reset = 1, reg_wr, reg_rd, button_fall_valid = 0;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, q;
  logic [1:0] active_mode = 0;
  logic       mode_zero_req, rail_apply;
  rail_ctrl_t rail_ctrl;
  int         error_cnt, samples_checked, cyc, i, a;
  logic [7:0] m [3] = '{8'h1C, 8'h4C, 8'h4F};
  logic [7:0] c [5] = '{8'h00, 8'h28, 8'h29, 8'h3E, 8'hFF};
  power_mode_two_config_regs uut (.clk_sys, .reset, .reg_addr, .reg_wr,
    .reg_wdata, .reg_rd, .reg_rdata, .active_mode, .button_fall_valid,
    .mode_zero_req, .rail_apply, .rail_ctrl);
  host_model host (.clk_sys, .reg_addr, .reg_wr, .reg_wdata, .reg_rd,
    .reg_rdata);
  initial forever #50 clk_sys = ~clk_sys;
  always @(posedge clk_sys)
    if (++cyc == 3000)
    begin
      error_cnt++;
      conclude();
    end
  function automatic rail_ctrl_t want();
    int k, s, v;
    k = m[0];
    s = m[1][4:0];
    v = m[2][7:4];
    want.core_buck_mv = 12'(k == 63 ? 1800 : 500 + 25 * (k > 40 ? 40 : k));
    want.sys_buck_mv = 12'(1500 + 25 * (s > 24 ? 24 : s) + 1200 * m[1][5]);
    want.aon_reg_mv = 12'(1700 + 25 * (v > 8 ? 8 : v));
    want[3:0] = m[2][3:0];
  endfunction
  task automatic check(input logic [63:0] seen, exp);
    samples_checked++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED %0t got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial
  begin
    void'($urandom(85));
    repeat (4) @(negedge clk_sys);
    reset = 0;
    for (i = 0; i < 4; i++)
    begin
      host.xfer(0, 8'h2A + 8'(i), 0, q);
      check(q, i < 3 ? m[i] : 8'h00);
    end
    active_mode = 2;
    // corner core codes, random for the other two registers
    for (i = 0; i < 15; i++)
    begin
      a = i % 3;
      m[a] = a == 0 ? c[i / 3] : 8'($urandom);
      host.xfer(1, 8'h2A + 8'(a), m[a], q);
      m[0] &= 8'h3F;
      host.xfer(0, 8'h2A + 8'(a), 0, q);
      check(q, m[a]);
      check({rail_apply, rail_ctrl}, {1'b1, want()});
    end
    for (i = 0; i < 4; i++)
    begin
      m[1] = {1'b0, i[0], 6'h0C};
      host.xfer(1, 8'h2B, m[1], q);
      @(negedge clk_sys) {active_mode, button_fall_valid} = {!i[1], 2'b01};
      @(negedge clk_sys) button_fall_valid = 0;
      check(mode_zero_req, !i[0] && !i[1]);
      check({rail_apply, rail_ctrl}, i[1] ? 0 : {1'b1, want()});
    end
    conclude();
  end
endmodule
